/* File: verilog/bsd_params.svh */
// register offsets, field positions, reset values and counts for the demapper config block
`ifndef BSD_PARAMS_SVH
`define BSD_PARAMS_SVH
`define BSD_OFS_GLOBAL 12'h9E0
`define BSD_OFS_ADDR 12'h9E3
`define BSD_OFS_CTRL 12'h9E4
`define BSD_OFS_MAPDATA 12'h9E5
`define BSD_OFS_TRIBDATA 12'h9E6
`define BSD_OFS_MODE 12'h9E8
`define BSD_GLOBAL_RESET 8'h41
`define BSD_BIT_ACTIVE_PAGE_SELECT 7
`define BSD_BIT_REMAP 2
`define BSD_BIT_RAMSEL 7
`define BSD_BIT_BUSY 7
`define BSD_BIT_ERR 6
`define BSD_BIT_RNW 1
`define BSD_BIT_PAGE 0
`define BSD_BIT_ON 0
`define BSD_TRIBUTARY_INDEX_MIN 5'h01
`define BSD_TRIBUTARY_INDEX_MAX 5'h1C
`define BSD_TRIBUTARY_INDEX_E1_LAST 5'h15
`define BSD_TRIBUTARY_INDEX_LOW_LAST 5'h01
`define BSD_ACCESS_CYCLES 2
`endif

/* File: verilog/bsd_pkg.sv */
// types shared by the demapper configuration block
package bsd_pkg;
  typedef struct packed {
    logic [1:0] group;
    logic [4:0] link;
  } bsd_map_entry_t;

  typedef struct packed {
    logic [1:0] group;
    logic [4:0] tributary_index;
  } bsd_tributary_index_addr_t;

  typedef enum logic [1:0] {
    BSD_MODE_OFF,
    BSD_MODE_BYTE_SYNC,
    BSD_MODE_BIT_ASYNC,
    BSD_MODE_TRANSPARENT
  } bsd_mode_t;

  typedef enum logic [1:0] {
    BSD_RATE_T1,
    BSD_RATE_E1,
    BSD_RATE_DS3
  } bsd_rate_t;
endpackage : bsd_pkg

/* File: verilog/bsd_map_ram.sv */
// two-page tributary-to-link mapping memory with straight reset image
`timescale 1ns/1ps
`include "bsd_params.svh"
module bsd_map_ram #(
  parameter int ENTRIES = 128
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic wr_en,
  input wire logic wr_page,
  input wire bsd_pkg::bsd_tributary_index_addr_t wr_addr,
  input wire bsd_pkg::bsd_map_entry_t wr_data,
  input wire logic rd_page,
  input wire bsd_pkg::bsd_tributary_index_addr_t rd_addr,
  output bsd_pkg::bsd_map_entry_t rd_data,
  input wire logic lk_page,
  input wire bsd_pkg::bsd_tributary_index_addr_t lk_addr,
  output bsd_pkg::bsd_map_entry_t lk_data
);
  import bsd_pkg::*;
  bsd_map_entry_t mem [2][ENTRIES];

  genvar p, e;
  generate
    for (p = 0; p < 2; p++) begin : g_page
      for (e = 0; e < ENTRIES; e++) begin : g_ent
        always_ff @(posedge clk or negedge nrst) begin
          if (!nrst) begin
            mem[p][e] <= bsd_map_entry_t'(7'(e));
          end else if (wr_en && wr_page == 1'(p) && wr_addr == 7'(e)) begin
            mem[p][e] <= wr_data;
          end
        end
      end
    end
  endgenerate

  assign rd_data = mem[rd_page][rd_addr];
  assign lk_data = mem[lk_page][lk_addr];
endmodule : bsd_map_ram

/* File: verilog/bsd_tributary_index_ram.sv */
// per-tributary control memory with per-entry configuration reset pulse
`timescale 1ns/1ps
`include "bsd_params.svh"
module bsd_tributary_index_ram #(
  parameter int ENTRIES = 128
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic wr_en,
  input wire bsd_pkg::bsd_tributary_index_addr_t wr_addr,
  input wire logic [6:0] wr_data,
  input wire bsd_pkg::bsd_tributary_index_addr_t rd_addr,
  output logic [6:0] rd_data,
  input wire bsd_pkg::bsd_tributary_index_addr_t lk_addr,
  output logic [6:0] lk_data,
  output logic [ENTRIES-1:0] cfg_reset
);
  import bsd_pkg::*;
  logic [6:0] mem [ENTRIES];

  genvar e;
  generate
    for (e = 0; e < ENTRIES; e++) begin : g_ent
      always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
          mem[e] <= 7'h00;
          cfg_reset[e] <= 1'b0;
        end else begin
          cfg_reset[e] <= wr_en && wr_addr == 7'(e);
          if (wr_en && wr_addr == 7'(e)) begin
            mem[e] <= wr_data;
          end
        end
      end
    end
  endgenerate

  assign rd_data = mem[rd_addr];
  assign lk_data = mem[lk_addr];
endmodule : bsd_tributary_index_ram

/* File: verilog/bsd_demap_config.sv */
// register bank and indirect-access engine of the byte synchronous demapper
// Operation
// - remap enable 0 gives one-to-one association; 1 uses active mapping page.
// - active page select picks mapping page one when set, zero when clear.
// - new active page takes effect only at next multiframe boundary.
// - RAM select 1 reaches mapping RAM, 0 reaches control RAM.
// - address is 2-bit group 1..3 and 5-bit tributary 1..28.
// - out-of-range indirect access sets the read-only illegal-access flag.
// - out of range: 2..28 for DS3/E3, 22..28 for E1, per group.
// - indirect page bit picks mapping page; ignored for control RAM.
// - read_not_write 0 starts indirect write, 1 starts read into data register.
// - busy rises on control write starting access, stays until access completes.
// - mapping entry holds 2-bit group and 5-bit link of destination.
// - after reset mapping is straight one-to-one through group 3 link 28.
// - tributary_on forwards drop-bus tributary data to its mapped link.
// - priority transparent, then bit-async provision, then tributary_on byte-sync.
// - all three clear fills tributary columns with zeros.
// - every control RAM write gives that tributary a configuration reset.
//
// Local design decision: the address-and-strobe port.
`timescale 1ns/1ps
`include "bsd_params.svh"
module bsd_demap_config #(
  parameter int ENTRIES = 128,
  parameter int ACCESS_CYCLES = `BSD_ACCESS_CYCLES
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic [11:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic multiframe_start,
  input wire logic transparent_tributary_bit,
  input wire logic bit_async_provision,
  input wire bsd_pkg::bsd_tributary_index_addr_t lookup_tributary_index,
  output bsd_pkg::bsd_map_entry_t lookup_link,
  output bsd_pkg::bsd_mode_t lookup_mode,
  output logic [ENTRIES-1:0] tributary_index_cfg_reset,
  output logic active_page_select
);
  import bsd_pkg::*;

  logic mf_meta;
  logic mf_sync;
  logic mf_prev;
  logic mf_edge;
  logic tt_meta;
  logic tt_sync;
  logic ba_meta;
  logic ba_sync;

  logic [7:0] global_ctrl;
  logic pending_page;
  logic page_live;
  logic remap_enable;
  bsd_rate_t rate_mode;
  logic [7:0] indirect_addr;
  logic read_not_write;
  logic ind_page;
  logic busy;
  logic illegal_access_flag;
  logic [6:0] map_data;
  logic [6:0] tributary_index_data;
  logic [1:0] busy_cnt;

  bsd_tributary_index_addr_t acc_addr;
  logic acc_map;
  logic acc_page;
  logic acc_rnw;
  logic acc_illegal;
  logic [6:0] acc_map_wdata;
  logic [6:0] acc_tributary_index_wdata;
  logic acc_done;

  bsd_map_entry_t map_rd;
  bsd_map_entry_t map_lk;
  logic [6:0] tributary_index_rd;
  logic [6:0] tributary_index_lk;
  logic [ENTRIES-1:0] cfg_rst;

  logic ctrl_wr;
  logic next_illegal;
  bsd_tributary_index_addr_t req_addr;
  bsd_map_entry_t next_link;
  bsd_mode_t next_mode;

  // level inputs from the drop-bus side pass two flops
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      mf_meta <= 1'b0;
      mf_sync <= 1'b0;
      mf_prev <= 1'b0;
      tt_meta <= 1'b0;
      tt_sync <= 1'b0;
      ba_meta <= 1'b0;
      ba_sync <= 1'b0;
    end else begin
      mf_meta <= multiframe_start;
      mf_sync <= mf_meta;
      mf_prev <= mf_sync;
      tt_meta <= transparent_tributary_bit;
      tt_sync <= tt_meta;
      ba_meta <= bit_async_provision;
      ba_sync <= ba_meta;
    end
  end

  assign mf_edge = mf_sync && !mf_prev;
  assign ctrl_wr = reg_wr && reg_addr == `BSD_OFS_CTRL && !busy;
  assign req_addr = bsd_tributary_index_addr_t'(indirect_addr[6:0]);

  // range check of the address at the moment the access starts
  always_comb begin
    next_illegal = 1'b0;
    if (req_addr.group == 2'h0 || req_addr.tributary_index < `BSD_TRIBUTARY_INDEX_MIN ||
        req_addr.tributary_index > `BSD_TRIBUTARY_INDEX_MAX) begin
      next_illegal = 1'b1;
    end else if (rate_mode == BSD_RATE_DS3 && req_addr.tributary_index > `BSD_TRIBUTARY_INDEX_LOW_LAST) begin
      next_illegal = 1'b1;
    end else if (rate_mode == BSD_RATE_E1 && req_addr.tributary_index > `BSD_TRIBUTARY_INDEX_E1_LAST) begin
      next_illegal = 1'b1;
    end
  end

  // global control and rate mode registers
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      global_ctrl <= `BSD_GLOBAL_RESET;
      rate_mode <= BSD_RATE_T1;
    end else if (reg_wr && reg_addr == `BSD_OFS_GLOBAL) begin
      global_ctrl <= reg_wdata;
    end else if (reg_wr && reg_addr == `BSD_OFS_MODE) begin
      rate_mode <= bsd_rate_t'(reg_wdata[1:0]);
    end
  end

  assign pending_page = global_ctrl[`BSD_BIT_ACTIVE_PAGE_SELECT];
  assign remap_enable = global_ctrl[`BSD_BIT_REMAP];

  // active page follows the register only on a multiframe boundary
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      page_live <= 1'b0;
    end else if (mf_edge) begin
      page_live <= pending_page;
    end
  end

  // address register and data registers
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      indirect_addr <= 8'h00;
      read_not_write <= 1'b0;
      ind_page <= 1'b0;
      map_data <= 7'h00;
      tributary_index_data <= 7'h00;
    end else begin
      if (reg_wr && reg_addr == `BSD_OFS_ADDR) begin
        indirect_addr <= reg_wdata;
      end
      if (ctrl_wr) begin
        read_not_write <= reg_wdata[`BSD_BIT_RNW];
        ind_page <= reg_wdata[`BSD_BIT_PAGE];
      end
      if (acc_done && acc_rnw && !acc_illegal) begin
        if (acc_map) begin
          map_data <= map_rd;
        end else begin
          tributary_index_data <= tributary_index_rd;
        end
      end else begin
        if (reg_wr && reg_addr == `BSD_OFS_MAPDATA) begin
          map_data <= reg_wdata[6:0];
        end
        if (reg_wr && reg_addr == `BSD_OFS_TRIBDATA) begin
          tributary_index_data <= reg_wdata[6:0];
        end
      end
    end
  end

  // indirect access engine: latch on start, hold while busy
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      busy <= 1'b0;
      busy_cnt <= 2'h0;
      acc_addr <= '0;
      acc_map <= 1'b0;
      acc_page <= 1'b0;
      acc_rnw <= 1'b0;
      acc_illegal <= 1'b0;
      acc_map_wdata <= 7'h00;
      acc_tributary_index_wdata <= 7'h00;
    end else if (ctrl_wr) begin
      busy <= 1'b1;
      busy_cnt <= 2'(ACCESS_CYCLES - 1);
      acc_addr <= req_addr;
      acc_map <= indirect_addr[`BSD_BIT_RAMSEL];
      acc_page <= reg_wdata[`BSD_BIT_PAGE];
      acc_rnw <= reg_wdata[`BSD_BIT_RNW];
      acc_illegal <= next_illegal;
      acc_map_wdata <= map_data;
      acc_tributary_index_wdata <= tributary_index_data;
    end else if (busy) begin
      if (busy_cnt == 2'h0) begin
        busy <= 1'b0;
      end else begin
        busy_cnt <= busy_cnt - 2'h1;
      end
    end
  end

  assign acc_done = busy && busy_cnt == 2'h0;

  // error flag reflects the last started access
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      illegal_access_flag <= 1'b0;
    end else if (ctrl_wr) begin
      illegal_access_flag <= next_illegal;
    end
  end

  bsd_map_ram #(.ENTRIES(ENTRIES)) u_map (
    .clk(clk),
    .nrst(nrst),
    .wr_en(acc_done && acc_map && !acc_rnw && !acc_illegal),
    .wr_page(acc_page),
    .wr_addr(acc_addr),
    .wr_data(bsd_map_entry_t'(acc_map_wdata)),
    .rd_page(acc_page),
    .rd_addr(acc_addr),
    .rd_data(map_rd),
    .lk_page(page_live),
    .lk_addr(lookup_tributary_index),
    .lk_data(map_lk)
  );

  bsd_tributary_index_ram #(.ENTRIES(ENTRIES)) u_tributary_index (
    .clk(clk),
    .nrst(nrst),
    .wr_en(acc_done && !acc_map && !acc_rnw && !acc_illegal),
    .wr_addr(acc_addr),
    .wr_data(acc_tributary_index_wdata),
    .rd_addr(acc_addr),
    .rd_data(tributary_index_rd),
    .lk_addr(lookup_tributary_index),
    .lk_data(tributary_index_lk),
    .cfg_reset(cfg_rst)
  );

  // datapath steering for the looked-up tributary
  always_comb begin
    next_link = remap_enable ? map_lk : bsd_map_entry_t'(lookup_tributary_index);
    if (tt_sync) begin
      next_mode = BSD_MODE_TRANSPARENT;
    end else if (ba_sync) begin
      next_mode = BSD_MODE_BIT_ASYNC;
    end else if (tributary_index_lk[`BSD_BIT_ON]) begin
      next_mode = BSD_MODE_BYTE_SYNC;
    end else begin
      next_mode = BSD_MODE_OFF;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      lookup_link <= '0;
      lookup_mode <= BSD_MODE_OFF;
      tributary_index_cfg_reset <= '0;
      active_page_select <= 1'b0;
    end else begin
      lookup_link <= next_link;
      lookup_mode <= next_mode;
      tributary_index_cfg_reset <= cfg_rst;
      active_page_select <= page_live;
    end
  end

  // register read port, data one cycle after the strobe
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      case (reg_addr)
        `BSD_OFS_GLOBAL: reg_rdata <= global_ctrl;
        `BSD_OFS_ADDR: reg_rdata <= indirect_addr;
        `BSD_OFS_CTRL: reg_rdata <= {busy, illegal_access_flag, 4'h0, read_not_write, ind_page};
        `BSD_OFS_MAPDATA: reg_rdata <= {1'b0, map_data};
        `BSD_OFS_TRIBDATA: reg_rdata <= {1'b0, tributary_index_data};
        `BSD_OFS_MODE: reg_rdata <= {6'h00, rate_mode};
        default: reg_rdata <= 8'h00;
      endcase
    end else begin
      reg_rdata <= 8'h00;
    end
  end

  page_hold_a: assert property (@(posedge clk) disable iff (!nrst)
    !mf_edge |=> page_live == $past(page_live)) else $error("page changed off boundary");
  page_take_a: assert property (@(posedge clk) disable iff (!nrst)
    mf_edge |=> page_live == $past(pending_page)) else $error("page not applied");
  busy_rise_a: assert property (@(posedge clk) disable iff (!nrst)
    ctrl_wr |=> busy) else $error("busy not set by start");
  busy_len_a: assert property (@(posedge clk) disable iff (!nrst)
    ctrl_wr |=> busy [*2] ##1 !busy) else $error("busy length wrong");
  err_range_a: assert property (@(posedge clk) disable iff (!nrst)
    ctrl_wr && req_addr.group == 2'h0 |=> illegal_access_flag) else $error("range miss");
  e1_range_a: assert property (@(posedge clk) disable iff (!nrst)
    ctrl_wr && rate_mode == BSD_RATE_E1 && req_addr.tributary_index == 5'h16
    |=> illegal_access_flag) else $error("e1 range miss");
  hold_data_a: assert property (@(posedge clk) disable iff (!nrst)
    busy && !ctrl_wr |=> $stable(acc_addr) && $stable(acc_map_wdata))
    else $error("latch moved");
  ctrl_hold_a: assert property (@(posedge clk) disable iff (!nrst)
    busy |=> $stable(acc_page) && $stable(acc_rnw) && $stable(acc_map))
    else $error("access mode moved");
  fixed_map_a: assert property (@(posedge clk) disable iff (!nrst)
    !remap_enable |=> lookup_link == $past(bsd_map_entry_t'(lookup_tributary_index)))
    else $error("fixed map wrong");
  mode_prio_a: assert property (@(posedge clk) disable iff (!nrst)
    tt_sync |=> lookup_mode == BSD_MODE_TRANSPARENT) else $error("priority wrong");
  async_prio_a: assert property (@(posedge clk) disable iff (!nrst)
    !tt_sync && ba_sync |=> lookup_mode == BSD_MODE_BIT_ASYNC)
    else $error("async priority wrong");
  mode_off_a: assert property (@(posedge clk) disable iff (!nrst)
    !tt_sync && !ba_sync && !tributary_index_lk[`BSD_BIT_ON] |=> lookup_mode == BSD_MODE_OFF)
    else $error("zero fill missing");
  cfg_pulse_a: assert property (@(posedge clk) disable iff (!nrst)
    acc_done && !acc_map && !acc_rnw && !acc_illegal
    |-> ##2 tributary_index_cfg_reset[$past(acc_addr, 2)]) else $error("no config reset");
  cfg_single_a: assert property (@(posedge clk) disable iff (!nrst)
    $onehot0(tributary_index_cfg_reset)) else $error("config reset on several tributaries");
  illegal_safe_a: assert property (@(posedge clk) disable iff (!nrst)
    acc_done && acc_illegal |-> ##2 tributary_index_cfg_reset == '0)
    else $error("illegal access touched a tributary");
endmodule : bsd_demap_config

/* File: dv/byte_sync_demapper_config_bench.sv */
// self-checking bench for the demapper configuration register bank
`timescale 1ns/1ps
`include "bsd_params.svh"
module byte_sync_demapper_config_bench;
  import bsd_pkg::*;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic [11:0] reg_addr = 12'h000;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_rdata;
  logic multiframe_start = 1'b0;
  logic transparent_tributary_bit = 1'b0;
  logic bit_async_provision = 1'b0;
  bsd_tributary_index_addr_t lookup_tributary_index = '0;
  bsd_map_entry_t lookup_link;
  bsd_mode_t lookup_mode;
  logic [127:0] tributary_index_cfg_reset;
  logic active_page_select;
  int err_total = 0;
  int compares = 0;
  int seed = 74;
  int hits;
  int others;
  logic [6:0] map_m [2][128];
  logic [6:0] rnd_idx [6];
  logic [6:0] d;
  logic [7:0] v;
  bsd_mode_t em;
  logic [1:0] rt [7] = '{2'h0, 2'h0, 2'h0, 2'h1, 2'h1, 2'h2, 2'h2};
  logic [6:0] ta [7] = '{7'h3C, 7'h3D, 7'h01, 7'h35, 7'h36, 7'h21, 7'h22};
  logic ex [7] = '{1'b0, 1'b1, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1};

  bsd_demap_config #(.ENTRIES(128), .ACCESS_CYCLES(`BSD_ACCESS_CYCLES)) DUT (
    .clk(clk), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .multiframe_start(multiframe_start),
    .transparent_tributary_bit(transparent_tributary_bit),
    .bit_async_provision(bit_async_provision), .lookup_tributary_index(lookup_tributary_index),
    .lookup_link(lookup_link), .lookup_mode(lookup_mode),
    .tributary_index_cfg_reset(tributary_index_cfg_reset), .active_page_select(active_page_select)
  );

  always #10 clk = ~clk;

  task automatic summarize;
    $display("compares %0d err_total %0d", compares, err_total);
    if (err_total == 0 && compares > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : summarize

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      err_total++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic wr(input logic [11:0] a, input logic [7:0] w);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= w;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [11:0] a, output logic [7:0] r);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    r = reg_rdata;
  endtask : rd

  // bounded busy poll; leaves last control read in st
  task automatic poll(output logic [7:0] st);
    int n = 0;
    do begin
      rd(`BSD_OFS_CTRL, st);
      n++;
    end while (st[7] !== 1'b0 && n < 20);
    if (st[7] !== 1'b0) begin
      err_total++;
      $display("[ERR] %0t busy never cleared", $time);
      summarize();
    end
  endtask : poll

  task automatic ind(input logic sel, input logic [6:0] t, input logic rnw, input logic pg,
                     output logic [7:0] st);
    wr(`BSD_OFS_ADDR, {sel, t});
    wr(`BSD_OFS_CTRL, {6'h00, rnw, pg});
    poll(st);
  endtask : ind

  task automatic look(input logic [6:0] t, output logic [6:0] l);
    @(posedge clk);
    lookup_tributary_index <= t;
    repeat (2) @(posedge clk);
    #1;
    l = lookup_link;
  endtask : look

  initial begin
    for (int i = 0; i < 128; i++) begin
      map_m[0][i] = 7'(i);
      map_m[1][i] = 7'(i);
    end
    repeat (20) @(posedge clk);
    nrst <= 1'b1;
    rd(`BSD_OFS_GLOBAL, v);
    check(v, `BSD_GLOBAL_RESET);
    rd(`BSD_OFS_ADDR, v);
    check(v, 8'h00);
    wr(12'h9EF, 8'h80);
    wr(12'h9E1, 8'hFF);
    rd(12'h9E1, v);
    check(v, 8'h00);
    rd(`BSD_OFS_GLOBAL, v);
    check(v, `BSD_GLOBAL_RESET);
    check({7'h00, active_page_select}, 8'h00);
    for (int g = 1; g < 4; g++) begin
      for (int p = 0; p < 2; p++) begin
        d = {2'(g), (p == 0) ? 5'h01 : 5'h1C};
        ind(1'b1, d, 1'b1, 1'(p), v);
        check({7'h00, v[6]}, 8'h00);
        rd(`BSD_OFS_MAPDATA, v);
        check({1'b0, v[6:0]}, {1'b0, map_m[p][d]});
      end
    end
    for (int i = 0; i < 6; i++) begin
      rnd_idx[i] = {2'(1 + ($unsigned($random(seed)) % 3)), 5'(1 + ($unsigned($random(seed)) % 28))};
      d = {2'(1 + ($unsigned($random(seed)) % 3)), 5'(1 + ($unsigned($random(seed)) % 28))};
      wr(`BSD_OFS_MAPDATA, {1'b0, d});
      ind(1'b1, rnd_idx[i], 1'b0, 1'b1, v);
      map_m[1][rnd_idx[i]] = d;
    end
    for (int i = 0; i < 6; i++) begin
      ind(1'b1, rnd_idx[i], 1'b1, 1'b1, v);
      rd(`BSD_OFS_MAPDATA, v);
      check({1'b0, v[6:0]}, {1'b0, map_m[1][rnd_idx[i]]});
      ind(1'b1, rnd_idx[i], 1'b1, 1'b0, v);
      rd(`BSD_OFS_MAPDATA, v);
      check({1'b0, v[6:0]}, {1'b0, map_m[0][rnd_idx[i]]});
    end
    // address rewritten while an indirect read is in flight
    wr(`BSD_OFS_ADDR, {1'b1, rnd_idx[0]});
    wr(`BSD_OFS_CTRL, 8'h03);
    wr(`BSD_OFS_ADDR, 8'hA1);
    poll(v);
    rd(`BSD_OFS_MAPDATA, v);
    check({1'b0, v[6:0]}, {1'b0, map_m[1][rnd_idx[0]]});
    for (int i = 0; i < 6; i++) begin
      look(rnd_idx[i], d);
      check({1'b0, d}, {1'b0, rnd_idx[i]});
    end
    wr(`BSD_OFS_GLOBAL, 8'h45);
    look(rnd_idx[0], d);
    check({1'b0, d}, {1'b0, map_m[0][rnd_idx[0]]});
    wr(`BSD_OFS_GLOBAL, 8'hC5);
    repeat (6) @(posedge clk);
    look(rnd_idx[0], d);
    check({1'b0, d}, {1'b0, map_m[0][rnd_idx[0]]});
    check({7'h00, active_page_select}, 8'h00);
    @(posedge clk);
    multiframe_start <= 1'b1;
    repeat (3) @(posedge clk);
    multiframe_start <= 1'b0;
    repeat (6) @(posedge clk);
    #1;
    check({7'h00, active_page_select}, 8'h01);
    for (int i = 0; i < 6; i++) begin
      look(rnd_idx[i], d);
      check({1'b0, d}, {1'b0, map_m[1][rnd_idx[i]]});
    end
    for (int i = 0; i < 7; i++) begin
      wr(`BSD_OFS_MODE, {6'h00, rt[i]});
      ind(1'b0, ta[i], 1'b1, 1'b0, v);
      check({7'h00, v[6]}, {7'h00, ex[i]});
    end
    wr(`BSD_OFS_MODE, 8'h00);
    for (int on = 0; on < 2; on++) begin
      for (int rep = 0; rep < 2; rep++) begin
        wr(`BSD_OFS_TRIBDATA, {7'h00, 1'(on)});
        wr(`BSD_OFS_ADDR, 8'h23);
        wr(`BSD_OFS_CTRL, 8'h00);
        hits = 0;
        others = 0;
        repeat (12) begin
          @(posedge clk);
          #1;
          if (tributary_index_cfg_reset[35] === 1'b1) hits++;
          if ((tributary_index_cfg_reset & ~(128'h1 << 35)) !== 128'h0) others++;
        end
        check(8'(hits), 8'h01);
        check(8'(others), 8'h00);
      end
      ind(1'b0, 7'h23, 1'b1, 1'b0, v);
      rd(`BSD_OFS_TRIBDATA, v);
      check({1'b0, v[6:0]}, {7'h00, 1'(on)});
      for (int k = 0; k < 4; k++) begin
        @(posedge clk);
        transparent_tributary_bit <= k[1];
        bit_async_provision <= k[0];
        lookup_tributary_index <= 7'h23;
        repeat (6) @(posedge clk);
        #1;
        em = k[1] ? BSD_MODE_TRANSPARENT : k[0] ? BSD_MODE_BIT_ASYNC :
             (on == 1) ? BSD_MODE_BYTE_SYNC : BSD_MODE_OFF;
        check({6'h00, lookup_mode}, {6'h00, em});
      end
    end
    summarize();
  end
endmodule : byte_sync_demapper_config_bench
